// *** src/vco_cfg_pkg.sv ***
// package for the oscillator subsystem configuration bank
// assumes one clock domain and a single indirect write strobe from the pll side
package vco_cfg_pkg;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned ID_W = 3;
  localparam int unsigned WORD_W = 17;
  // indirect word layout
  localparam int unsigned ID_LSB = 0;
  localparam int unsigned ADDR_LSB = 3;
  localparam int unsigned DATA_LSB = 7;
  localparam logic [2:0] SUBSYS_ID = 3'h0;
  // register indices
  localparam logic [3:0] REG_TUNING = 4'h0;
  localparam logic [3:0] REG_ENABLES = 4'h1;
  localparam logic [3:0] REG_DIV_GAIN = 4'h2;
  localparam logic [3:0] REG_CONFIG = 4'h3;
  localparam logic [3:0] REG_BIAS = 4'h4;
  localparam logic [3:0] REG_COARSE = 4'h5;
  localparam logic [3:0] REG_MSB = 4'h6;
  localparam int unsigned NUM_REGS = 7;
  // reset values
  localparam logic [8:0] RST_TUNING = 9'h020;
  localparam logic [8:0] RST_ENABLES = 9'h01F;
  localparam logic [8:0] RST_DIV_GAIN = 9'h0C1;
  localparam logic [8:0] RST_CONFIG = 9'h051;
  localparam logic [8:0] RST_BIAS = 9'h0C9;
  localparam logic [8:0] RST_COARSE = 9'h0AA;
  localparam logic [8:0] RST_MSB = 9'h0FF;
  // field positions
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned BUF_GAIN_LSB = 6;
  localparam int unsigned STAGE_GAIN_BIT = 8;
  localparam int unsigned FUND_BIT = 0;
  localparam int unsigned MANUAL_BIT = 2;
  localparam int unsigned BIAS_LSB = 3;
  localparam int unsigned MASTER_BIT = 0;
  localparam int unsigned PLLBUF_BIT = 1;
  localparam int unsigned RFBUF_BIT = 2;
  localparam int unsigned DIV1_BIT = 3;
  localparam int unsigned RFDIV_BIT = 4;
  localparam int unsigned CAL_BIT = 0;
  localparam int unsigned CAPS_LSB = 1;
  localparam int unsigned MSB_FIELD_W = 8;
  localparam logic [5:0] DIV_MAX = 6'h3E;
  localparam logic [5:0] DIV_MUTE = 6'h00;
  localparam logic [5:0] DIV_ONE = 6'h01;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
  } indirect_write_t;

  typedef struct packed {
    logic oscEnable;
    logic pllBufEnable;
    logic rfBufEnable;
    logic div1Enable;
    logic rfDivEnable;
    logic [5:0] divideRatio;
    logic [1:0] bufferGain;
    logic stageGainMax;
    logic fundamentalMode;
    logic [1:0] rfBufferBias;
    logic calMode;
    logic [7:0] subBand;
    logic [8:0] biasTrim;
    logic [8:0] coarseTrim;
    logic [7:0] upperTrim;
  } vco_control_t;
endpackage

// *** src/vco_reg_store.sv ***
// small register store for the oscillator subsystem words
// assumes writes arrive already decoded, one per cycle
`timescale 1ns/1ps
module vco_reg_store (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic writeEnable,
  input wire logic [vco_cfg_pkg::ADDR_W-1:0] writeAddr,
  input wire logic [vco_cfg_pkg::DATA_W-1:0] writeData,
  output logic [vco_cfg_pkg::NUM_REGS*vco_cfg_pkg::DATA_W-1:0] regWords
);
  import vco_cfg_pkg::*;

  // reset image, word 0 in the low bits
  localparam logic [NUM_REGS*DATA_W-1:0] RESET_WORDS = {RST_MSB, RST_COARSE, RST_BIAS, RST_CONFIG, RST_DIV_GAIN,
    RST_ENABLES, RST_TUNING};

  ////////////////////////////////////////////////////////////
  // only addressed word updates
  // one process owns the whole image so every bit has a single driver
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regWords <= RESET_WORDS;
    end else if (writeEnable) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (writeAddr == ADDR_W'(i)) begin
          regWords[i*DATA_W +: DATA_W] <= writeData;
        end
      end
    end
  end
endmodule

// *** src/vco_subsystem_config_regs.sv ***
// oscillator subsystem configuration bank with output-stage control decode
// assumes the pll-side serial port hands over a completed indirect word as a one-cycle strobe on clk
`timescale 1ns/1ps
module vco_subsystem_config_regs (
  input wire logic clk,
  input wire logic reset_n,
  input vco_cfg_pkg::indirect_write_t indirectWrite,
  output vco_cfg_pkg::vco_control_t control
);
  import vco_cfg_pkg::*;

  logic [NUM_REGS*DATA_W-1:0] regWords;
  logic storeWrite;
  logic [ADDR_W-1:0] storeAddr;
  logic [DATA_W-1:0] storeData;
  // raw words of the store
  logic [DATA_W-1:0] tuningWord;
  logic [DATA_W-1:0] enablesWord;
  logic [DATA_W-1:0] divGainWord;
  logic [DATA_W-1:0] cfgWord;
  logic [DATA_W-1:0] biasWord;
  logic [DATA_W-1:0] coarseWord;
  logic [DATA_W-1:0] msbWord;
  // decoded mode and ratio
  logic master;
  logic manual;
  logic [DIV_W-1:0] ratio;
  logic next_oscEnable;
  logic next_pllBufEnable;
  logic next_rfBufEnable;
  logic next_div1Enable;
  logic next_rfDivEnable;
  // output flops, one group per concern
  logic oscEnable;
  logic pllBufEnable;
  logic rfBufEnable;
  logic div1Enable;
  logic rfDivEnable;
  logic [DIV_W-1:0] divideRatio;
  logic [1:0] bufferGain;
  logic stageGainMax;
  logic fundamentalMode;
  logic [1:0] rfBufferBias;
  logic calMode;
  logic [7:0] subBand;
  logic [DATA_W-1:0] biasTrim;
  logic [DATA_W-1:0] coarseTrim;
  logic [MSB_FIELD_W-1:0] upperTrim;

  function automatic logic [DATA_W-1:0] regAt(input logic [NUM_REGS*DATA_W-1:0] words, input int unsigned idx);
    regAt = words[idx*DATA_W +: DATA_W];
  endfunction

  function automatic logic [5:0] effectiveRatio(input logic [5:0] raw);
    logic [5:0] clamped;
    clamped = (raw > DIV_MAX) ? DIV_MAX : raw;
    if (clamped == DIV_MUTE || clamped == DIV_ONE) begin
      effectiveRatio = clamped;
    end else begin
      effectiveRatio = {clamped[5:1], 1'b0};
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // decode indirect word
  always_comb begin
    storeWrite = indirectWrite.valid && indirectWrite.word[ID_LSB +: ID_W] == SUBSYS_ID;
    storeAddr = indirectWrite.word[ADDR_LSB +: ADDR_W];
    storeData = indirectWrite.word[DATA_LSB +: DATA_W];
  end

  vco_reg_store u_store (
    .clk(clk),
    .reset_n(reset_n),
    .writeEnable(storeWrite),
    .writeAddr(storeAddr),
    .writeData(storeData),
    .regWords(regWords)
  );

  ////////////////////////////////////////////////////////////
  // raw views of the stored words
  always_comb begin
    tuningWord = regAt(regWords, int'(REG_TUNING));
    enablesWord = regAt(regWords, int'(REG_ENABLES));
    divGainWord = regAt(regWords, int'(REG_DIV_GAIN));
    cfgWord = regAt(regWords, int'(REG_CONFIG));
    biasWord = regAt(regWords, int'(REG_BIAS));
    coarseWord = regAt(regWords, int'(REG_COARSE));
    msbWord = regAt(regWords, int'(REG_MSB));
  end

  ////////////////////////////////////////////////////////////
  always_comb begin
    master = enablesWord[MASTER_BIT];
    manual = cfgWord[MANUAL_BIT];
    ratio = effectiveRatio(divGainWord[DIV_LSB +: DIV_W]);
    // lsb dropped in manual
    // a manual divide by one therefore shows as zero
    if (manual) begin
      ratio = {ratio[DIV_W-1:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////
  // master off kills all
  // auto ignores local bits and decodes master and ratio, manual ands them with master
  always_comb begin
    next_oscEnable = master;
    if (manual) begin
      next_pllBufEnable = master & enablesWord[PLLBUF_BIT];
      next_rfBufEnable = master & enablesWord[RFBUF_BIT];
      next_div1Enable = master & enablesWord[DIV1_BIT];
      next_rfDivEnable = master & enablesWord[RFDIV_BIT];
    end else begin
      next_pllBufEnable = master;
      next_rfBufEnable = master && ratio != DIV_MUTE;
      next_div1Enable = master && ratio == DIV_ONE;
      next_rfDivEnable = master && ratio != DIV_MUTE && ratio != DIV_ONE;
    end
  end

  ////////////////////////////////////////////////////////////
  // stage enables, one cycle after the store
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscEnable <= 1'b0;
      pllBufEnable <= 1'b0;
      rfBufEnable <= 1'b0;
      div1Enable <= 1'b0;
      rfDivEnable <= 1'b0;
    end else begin
      oscEnable <= next_oscEnable;
      pllBufEnable <= next_pllBufEnable;
      rfBufEnable <= next_rfBufEnable;
      div1Enable <= next_div1Enable;
      rfDivEnable <= next_rfDivEnable;
    end
  end

  // divide ratio and output gains
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divideRatio <= '0;
      bufferGain <= '0;
      stageGainMax <= 1'b0;
    end else begin
      divideRatio <= ratio;
      bufferGain <= divGainWord[BUF_GAIN_LSB +: 2];
      stageGainMax <= divGainWord[STAGE_GAIN_BIT];
    end
  end

  // band mode and buffer bias
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fundamentalMode <= 1'b0;
      rfBufferBias <= '0;
    end else begin
      fundamentalMode <= cfgWord[FUND_BIT];
      rfBufferBias <= cfgWord[BIAS_LSB +: 2];
    end
  end

  // tuning word, held for the tuning logic elsewhere
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      calMode <= 1'b0;
      subBand <= '0;
    end else begin
      calMode <= tuningWord[CAL_BIT];
      subBand <= tuningWord[CAPS_LSB +: 8];
    end
  end

  // fixed trims, passed on as loaded; unsupported values are not filtered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      biasTrim <= '0;
      coarseTrim <= '0;
      upperTrim <= '0;
    end else begin
      biasTrim <= biasWord;
      coarseTrim <= coarseWord;
      upperTrim <= msbWord[MSB_FIELD_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // output is pure wiring of the flops above
  always_comb begin
    control.oscEnable = oscEnable;
    control.pllBufEnable = pllBufEnable;
    control.rfBufEnable = rfBufEnable;
    control.div1Enable = div1Enable;
    control.rfDivEnable = rfDivEnable;
    control.divideRatio = divideRatio;
    control.bufferGain = bufferGain;
    control.stageGainMax = stageGainMax;
    control.fundamentalMode = fundamentalMode;
    control.rfBufferBias = rfBufferBias;
    control.calMode = calMode;
    control.subBand = subBand;
    control.biasTrim = biasTrim;
    control.coarseTrim = coarseTrim;
    control.upperTrim = upperTrim;
  end
endmodule

// *** tb/vco_subsystem_config_regs_properties.sv ***
// checker for the oscillator configuration bank
// assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
module vco_subsystem_config_regs_properties (
  input wire logic clk,
  input wire logic reset_n,
  input vco_cfg_pkg::indirect_write_t indirectWrite,
  input vco_cfg_pkg::vco_control_t control
);
  import vco_cfg_pkg::*;
  logic manualMode;
  wire take = indirectWrite.valid && indirectWrite.word[2:0] == SUBSYS_ID;
  wire [3:0] wAddr = indirectWrite.word[6:3];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // copy of the mode bit, control trails it by one edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      manualMode <= 1'b0;
    end else if (take && wAddr == REG_CONFIG) begin
      manualMode <= indirectWrite.word[9];
    end
  end
  ////////////////////////////////////////////////////////////////
  a_ratio_even_clamp: assert property (control.divideRatio <= DIV_MAX && !(control.divideRatio[0] && control.divideRatio != DIV_ONE))
    else $error("ratio not even or above limit");
  a_ratio_load: assert property (take && wAddr == REG_DIV_GAIN && !indirectWrite.word[7] && |indirectWrite.word[12:8]
    |-> ##2 control.divideRatio == $past(indirectWrite.word[12:7], 2)) else $error("even ratio not applied");
  a_gain_load: assert property (take && wAddr == REG_DIV_GAIN |-> ##2
    {control.stageGainMax, control.bufferGain} == $past(indirectWrite.word[15:13], 2)) else $error("gain not applied");
  a_idle_stable: assert property ((!take || wAddr > REG_MSB)[*2] |=> $stable(control))
    else $error("control moved without write");
  a_master_off: assert property (!control.oscEnable |-> !(control.pllBufEnable || control.rfBufEnable
    || control.div1Enable || control.rfDivEnable)) else $error("stage on with master off");
  a_auto_enables: assert property (!$past(manualMode) |-> control.div1Enable == (control.oscEnable && control.divideRatio == DIV_ONE)
    && control.rfDivEnable == (control.oscEnable && control.divideRatio > DIV_ONE)) else $error("auto enable wrong");
  a_mute_stages: assert property (!$past(manualMode) |-> control.pllBufEnable == control.oscEnable
    && control.rfBufEnable == (control.oscEnable && control.divideRatio != DIV_MUTE)) else $error("mute wrong");
  a_manual_lsb: assert property ($past(manualMode) |-> !control.divideRatio[0])
    else $error("ratio lsb kept in manual");
  c_ratio_write: cover property (take && wAddr == REG_DIV_GAIN);
  c_manual_div: cover property ($past(manualMode) && control.rfDivEnable);
  c_master_off: cover property (!control.oscEnable);
endmodule
bind vco_subsystem_config_regs vco_subsystem_config_regs_properties i_vco_subsystem_config_regs_properties (
  .clk(clk), .reset_n(reset_n), .indirectWrite(indirectWrite), .control(control));

// *** tb/vco_host_model.sv ***
// host model loading the bank through the indirect word
// assumes writes launch 1 ns after a rising clk edge
`timescale 1ns/1ps
module vco_host_model (
  input wire logic clk,
  output vco_cfg_pkg::indirect_write_t indirectWrite
);
  import vco_cfg_pkg::*;
  initial indirectWrite = '0;
  task automatic send(input logic [3:0] a, input logic [8:0] d, input logic [2:0] id = SUBSYS_ID);
    @(posedge clk);
    #1;
    indirectWrite = {1'b1, 1'b0, d, a, id};
  endtask
  // released word flips so a stale copy never looks valid
  task automatic idle();
    @(posedge clk);
    #1;
    indirectWrite = {1'b0, ~indirectWrite.word};
  endtask
  task automatic trims();
    send(REG_BIAS, 9'h0C1);
    send(REG_COARSE, 9'h02C);
    send(REG_MSB, 9'h1FF);
  endtask
endmodule

// *** tb/vco_subsystem_config_regs_tb.sv ***
// self-checking bench for the oscillator configuration bank
// assumes the host model makes every write and the checker is bound in
`timescale 1ns/1ps
module vco_subsystem_config_regs_tb;
  import vco_cfg_pkg::*;
  logic clk;
  logic reset_n = 1'b0;
  indirect_write_t indirectWrite;
  vco_control_t control;
  int n_errors = 0;
  int samples_checked = 0;
  vco_subsystem_config_regs i_vco_subsystem_config_regs (.clk(clk), .reset_n(reset_n),
    .indirectWrite(indirectWrite), .control(control));
  vco_host_model i_vco_host_model (.clk(clk), .indirectWrite(indirectWrite));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    i_vco_host_model.idle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic test_ratio();
    logic [5:0] r [8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3D, 6'h3E, 6'h3F, 6'h2A};
    logic [5:0] e;
    for (int i = 0; i < 8; i++) begin
      i_vco_host_model.send(REG_DIV_GAIN, {r[i] < 6'h03, i[1:0], r[i]});
      i_vco_host_model.send(REG_DIV_GAIN, 9'h000, 3'h1);
      settle();
      e = r[i] > DIV_MAX ? DIV_MAX : (r[i] > DIV_ONE ? r[i] & 6'h3E : r[i]);
      chk({control.divideRatio, control.bufferGain, control.stageGainMax}, {e, i[1:0], r[i] < 6'h03});
      chk({control.rfBufEnable, control.div1Enable, control.rfDivEnable}, {e != 0, e == 1, e > 1});
    end
    $display("test_ratio done");
  endtask
  task automatic test_manual();
    i_vco_host_model.send(REG_CONFIG, 9'h000);
    settle();
    chk({control.fundamentalMode, control.rfBufferBias}, 3'h0);
    i_vco_host_model.send(REG_CONFIG, 9'h015);
    i_vco_host_model.send(REG_ENABLES, 9'h01B);
    i_vco_host_model.send(REG_DIV_GAIN, 9'h0C1);
    settle();
    chk({control.pllBufEnable, control.rfBufEnable, control.div1Enable, control.rfDivEnable}, 4'hB);
    chk(control.divideRatio, 6'h00);
    i_vco_host_model.send(REG_ENABLES, 9'h01E);
    i_vco_host_model.send(4'h9, 9'h1FF);
    settle();
    chk({control.oscEnable, control.pllBufEnable, control.rfBufEnable, control.rfDivEnable}, 4'h0);
    i_vco_host_model.send(REG_CONFIG, 9'h011);
    i_vco_host_model.send(REG_ENABLES, 9'h01F);
    settle();
    chk({control.oscEnable, control.pllBufEnable, control.rfBufEnable, control.div1Enable, control.rfDivEnable}, 5'h1E);
    $display("test_manual done");
  endtask
  task automatic test_trims();
    i_vco_host_model.trims();
    i_vco_host_model.send(REG_TUNING, 9'h0FF);
    settle();
    chk({control.biasTrim, control.coarseTrim, control.upperTrim}, {9'h0C1, 9'h02C, 8'hFF});
    chk({control.calMode, control.subBand}, {1'b1, 8'h7F});
    $display("test_trims done");
  endtask
  task automatic test_reset();
    chk({control.divideRatio, control.bufferGain, control.stageGainMax, control.fundamentalMode}, 10'h01D);
    chk({control.coarseTrim, control.upperTrim, control.subBand}, {9'h0AA, 8'hFF, 8'h10});
    chk(control.calMode, 1'b0);
    chk({control.oscEnable, control.pllBufEnable, control.rfBufEnable, control.div1Enable, control.rfDivEnable}, 5'h1E);
    chk({control.rfBufferBias, control.biasTrim}, {2'h2, 9'h0C9});
    $display("test_reset done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_ratio();
    test_manual();
    test_trims();
    end_of_test();
  end
  initial begin
    #5000;
    n_errors++;
    end_of_test();
  end
endmodule
